// *** common/tpg_cfg_if.sv ***
// Interface carrying the programmed line settings to the byte emitter.
// Assumes both ends share core_clk.
interface tpg_cfg_if;
  logic [15:0] line_length_bytes;
  logic [15:0] bar_width_bytes;
  logic [1:0]  bar_count_select;

  modport src (output line_length_bytes, bar_width_bytes,
               bar_count_select);
  modport dst (input line_length_bytes, bar_width_bytes,
               bar_count_select);
endinterface

// *** common/tpg_pkg.sv ***
// Constants and types shared by the test pattern frame timing block.
// Assumes a single core clock of 100 MHz and byte-wide register access.
package tpg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 10;
  // Cycles per line period tick, rounded up, never below one.
  localparam int unsigned CYC_PER_TICK  =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL        = 8'h01;
  localparam logic [7:0] OFS_CFG         = 8'h02;
  localparam logic [7:0] OFS_LINE_LEN_HI = 8'h04;
  localparam logic [7:0] OFS_LINE_LEN_LO = 8'h05;
  localparam logic [7:0] OFS_BAR_WID_HI  = 8'h06;
  localparam logic [7:0] OFS_BAR_WID_LO  = 8'h07;
  localparam logic [7:0] OFS_ACT_HI      = 8'h08;
  localparam logic [7:0] OFS_ACT_LO      = 8'h09;
  localparam logic [7:0] OFS_TOT_HI      = 8'h0A;
  localparam logic [7:0] OFS_TOT_LO      = 8'h0B;
  localparam logic [7:0] OFS_PERIOD_HI   = 8'h0C;
  localparam logic [7:0] OFS_PERIOD_LO   = 8'h0D;
  localparam logic [7:0] OFS_BACK_PORCH  = 8'h0E;
  localparam logic [7:0] OFS_FRONT_PORCH = 8'h0F;
  localparam logic [7:0] OFS_LINE_IDX_HI = 8'h1C;
  localparam logic [7:0] OFS_LINE_IDX_LO = 8'h1D;
  localparam logic [7:0] OFS_STATUS      = 8'h1E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL        = 8'h00;
  localparam logic [7:0] RST_CFG         = 8'h33;
  localparam logic [7:0] RST_LINE_LEN_HI = 8'h07;
  localparam logic [7:0] RST_LINE_LEN_LO = 8'h80;
  localparam logic [7:0] RST_BAR_WID_HI  = 8'h00;
  localparam logic [7:0] RST_BAR_WID_LO  = 8'hF0;
  localparam logic [7:0] RST_ACT_HI      = 8'h01;
  localparam logic [7:0] RST_ACT_LO      = 8'hE0;
  localparam logic [7:0] RST_TOT_HI      = 8'h02;
  localparam logic [7:0] RST_TOT_LO      = 8'h0D;
  localparam logic [7:0] RST_PERIOD_HI   = 8'h0C;
  localparam logic [7:0] RST_PERIOD_LO   = 8'h67;
  localparam logic [7:0] RST_BACK_PORCH  = 8'h21;
  localparam logic [7:0] RST_FRONT_PORCH = 8'h0A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ON_BIT   = 0;
  localparam int unsigned CFG_BARS_LSB  = 4;
  localparam int unsigned STAT_RUN_BIT  = 0;
  localparam int unsigned STAT_FRM_BIT  = 1;
  localparam int unsigned STAT_LINE_BIT = 2;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01
  } tpg_state_t;

endpackage

// *** hw/tpg_line.sv ***
// Byte emitter for one active line, split into color bars.
// Assumes the transmitter accepts one byte on every cycle.
module tpg_line (
  input  wire logic  core_clk,
  input  wire logic  srst,
  tpg_cfg_if.dst     cfg,
  input  wire logic  line_go,
  output logic       byte_valid,
  output logic [2:0] bar_index,
  output logic       line_first,
  output logic       line_last,
  output logic       line_busy
);

  typedef struct packed {
    logic        busy;
    logic [15:0] len;
    logic [15:0] wid;
    logic [2:0]  bars_m1;
    logic [15:0] cnt;
    logic [15:0] bar_cnt;
    logic [2:0]  bar;
    logic        valid;
    logic [2:0]  bar_out;
    logic        first;
    logic        last;
  } tpg_line_st_t;

  tpg_line_st_t q;
  tpg_line_st_t d;

  // Index of the final bar for codes 00, 01, 10, 11.
  function automatic logic [2:0] last_bar(input logic [1:0] sel);
    last_bar = 3'((4'h1 << sel) - 4'h1);
  endfunction

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    d.first = 1'b0;
    d.last = 1'b0;
    if (!q.busy)
    begin
      // Settings are frozen for the whole line.
      if (line_go && cfg.line_length_bytes != 16'h0000)
      begin
        d.busy = 1'b1;
        d.len = cfg.line_length_bytes;
        d.wid = cfg.bar_width_bytes;
        d.bars_m1 = last_bar(cfg.bar_count_select);
        d.cnt = 16'h0000;
        d.bar_cnt = 16'h0000;
        d.bar = 3'h0;
      end
    end
    else
    begin
      d.valid = 1'b1;
      d.bar_out = q.bar;
      d.first = (q.cnt == 16'h0000);
      d.last = (q.cnt == q.len - 16'h0001);
      d.cnt = q.cnt + 16'h0001;
      if (d.last)
        d.busy = 1'b0;
      // The final bar never advances and takes the remaining bytes.
      if (q.bar != q.bars_m1 && q.bar_cnt == q.wid - 16'h0001)
      begin
        d.bar = q.bar + 3'h1;
        d.bar_cnt = 16'h0000;
      end
      else
        d.bar_cnt = q.bar_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  assign byte_valid = q.valid;
  assign bar_index  = q.bar_out;
  assign line_first = q.first;
  assign line_last  = q.last;
  assign line_busy  = q.busy;

endmodule // tpg_line

// *** hw/tpg_tick.sv ***
// Line period timer: one pulse per programmed line period.
// Assumes run is a registered level from the frame sequencer.
module tpg_tick (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic [15:0] period_ticks,
  output logic             line_tick
);

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } tpg_tick_st_t;

  tpg_tick_st_t q;
  tpg_tick_st_t d;
  logic [23:0]  span;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    // A zero period is treated as one tick.
    if (period_ticks == 16'h0000)
      span = 24'(tpg_pkg::CYC_PER_TICK);
    else
      span = 24'(period_ticks * tpg_pkg::CYC_PER_TICK);
    if (!run)
      d.cnt = 24'h000000;
    else if (q.cnt == 24'h000000)
    begin
      d.tick = 1'b1;
      d.cnt = span - 24'h000001;
    end
    else
      d.cnt = q.cnt - 24'h000001;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  assign line_tick = q.tick;

endmodule // tpg_tick

// *** hw/tpg_top.sv ***
// Frame and line timing core of the test pattern generator.
// Assumes byte-wide register access from the indirect page logic and
// a packet transmitter on core_clk that takes every strobe it is given.
module tpg_top (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            frame_start,
  output logic            frame_end,
  output logic            blank_line,
  output logic            frame_active,
  output logic            byte_valid,
  output logic      [2:0] bar_index,
  output logic            line_first,
  output logic            line_last
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef logic [15:1][7:0] tpg_regs_t;

  typedef struct packed {
    tpg_regs_t           regs;
    logic [7:0]          rdata;
    tpg_pkg::tpg_state_t st;
    logic [15:0]         line_idx;
    logic                fs;
    logic                fe;
    logic                blank;
    logic                go;
    logic                in_frame;
  } tpg_top_st_t;

  tpg_top_st_t q;
  tpg_top_st_t d;

  tpg_cfg_if   cfg ();
  logic        line_tick;
  logic        line_busy;
  logic        gen_on;
  logic [15:0] act_lines;
  logic [15:0] tot_lines;
  logic [15:0] period;
  logic [15:0] vbp;
  logic [15:0] vfp;
  logic [15:0] act_first;
  logic [15:0] act_last;
  logic [15:0] fe_idx;
  logic [15:0] next_idx;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // True for the byte registers held in the settings array.
  function automatic logic is_setting(input logic [7:0] a);
    is_setting = (a[7:4] == 4'h0) && (a[3:0] != 4'h0) &&
                 (a != 8'h03);
  endfunction

  function automatic tpg_regs_t reg_defaults();
    tpg_regs_t r;
    r = '0;
    r[4'(tpg_pkg::OFS_CTRL)]        = tpg_pkg::RST_CTRL;
    r[4'(tpg_pkg::OFS_CFG)]         = tpg_pkg::RST_CFG;
    r[4'(tpg_pkg::OFS_LINE_LEN_HI)] = tpg_pkg::RST_LINE_LEN_HI;
    r[4'(tpg_pkg::OFS_LINE_LEN_LO)] = tpg_pkg::RST_LINE_LEN_LO;
    r[4'(tpg_pkg::OFS_BAR_WID_HI)]  = tpg_pkg::RST_BAR_WID_HI;
    r[4'(tpg_pkg::OFS_BAR_WID_LO)]  = tpg_pkg::RST_BAR_WID_LO;
    r[4'(tpg_pkg::OFS_ACT_HI)]      = tpg_pkg::RST_ACT_HI;
    r[4'(tpg_pkg::OFS_ACT_LO)]      = tpg_pkg::RST_ACT_LO;
    r[4'(tpg_pkg::OFS_TOT_HI)]      = tpg_pkg::RST_TOT_HI;
    r[4'(tpg_pkg::OFS_TOT_LO)]      = tpg_pkg::RST_TOT_LO;
    r[4'(tpg_pkg::OFS_PERIOD_HI)]   = tpg_pkg::RST_PERIOD_HI;
    r[4'(tpg_pkg::OFS_PERIOD_LO)]   = tpg_pkg::RST_PERIOD_LO;
    r[4'(tpg_pkg::OFS_BACK_PORCH)]  = tpg_pkg::RST_BACK_PORCH;
    r[4'(tpg_pkg::OFS_FRONT_PORCH)] = tpg_pkg::RST_FRONT_PORCH;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Settings view
  // ----------------------------------------------------------------
  // Each 16-bit value joins the lower offset as its high byte.
  assign gen_on = q.regs[4'(tpg_pkg::OFS_CTRL)][tpg_pkg::CTRL_ON_BIT];
  assign act_lines = {q.regs[4'(tpg_pkg::OFS_ACT_HI)],
                      q.regs[4'(tpg_pkg::OFS_ACT_LO)]};
  assign tot_lines = {q.regs[4'(tpg_pkg::OFS_TOT_HI)],
                      q.regs[4'(tpg_pkg::OFS_TOT_LO)]};
  assign period    = {q.regs[4'(tpg_pkg::OFS_PERIOD_HI)],
                      q.regs[4'(tpg_pkg::OFS_PERIOD_LO)]};
  assign vbp = {8'h00, q.regs[4'(tpg_pkg::OFS_BACK_PORCH)]};
  assign vfp = {8'h00, q.regs[4'(tpg_pkg::OFS_FRONT_PORCH)]};

  assign cfg.line_length_bytes = {q.regs[4'(tpg_pkg::OFS_LINE_LEN_HI)],
                                  q.regs[4'(tpg_pkg::OFS_LINE_LEN_LO)]};
  assign cfg.bar_width_bytes = {q.regs[4'(tpg_pkg::OFS_BAR_WID_HI)],
                                q.regs[4'(tpg_pkg::OFS_BAR_WID_LO)]};
  assign cfg.bar_count_select =
    q.regs[4'(tpg_pkg::OFS_CFG)][tpg_pkg::CFG_BARS_LSB +: 2];

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  // Line 0 carries frame start, then back porch, video, front porch,
  // the frame end line, and idle blanking up to the total.
  assign act_first = vbp + 16'h0001;
  assign act_last  = vbp + act_lines;
  assign fe_idx    = act_last + vfp + 16'h0001;
  assign next_idx  = q.line_idx + 16'h0001;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.fs = 1'b0;
    d.fe = 1'b0;
    d.blank = 1'b0;
    d.go = 1'b0;

    if (reg_wr && is_setting(reg_addr))
      d.regs[reg_addr[3:0]] = reg_wdata;

    if (reg_rd)
    begin
      if (is_setting(reg_addr))
        d.rdata = q.regs[reg_addr[3:0]];
      else if (reg_addr == tpg_pkg::OFS_LINE_IDX_HI)
        d.rdata = q.line_idx[15:8];
      else if (reg_addr == tpg_pkg::OFS_LINE_IDX_LO)
        d.rdata = q.line_idx[7:0];
      else if (reg_addr == tpg_pkg::OFS_STATUS)
      begin
        d.rdata = 8'h00;
        d.rdata[tpg_pkg::STAT_RUN_BIT] = (q.st == tpg_pkg::ST_RUN);
        d.rdata[tpg_pkg::STAT_FRM_BIT] = q.in_frame;
        d.rdata[tpg_pkg::STAT_LINE_BIT] = line_busy;
      end
      else
        d.rdata = 8'h00;
    end

    case (q.st)
      tpg_pkg::ST_OFF:
      begin
        d.line_idx = 16'h0000;
        d.in_frame = 1'b0;
        if (gen_on)
          d.st = tpg_pkg::ST_RUN;
      end
      tpg_pkg::ST_RUN:
      begin
        if (!gen_on)
        begin
          d.st = tpg_pkg::ST_OFF;
          d.line_idx = 16'h0000;
          d.in_frame = 1'b0;
        end
        else if (line_tick)
        begin
          if (q.line_idx == 16'h0000)
          begin
            d.fs = 1'b1;
            d.in_frame = 1'b1;
          end
          else if (q.line_idx >= act_first &&
                   q.line_idx <= act_last)
            d.go = 1'b1;
          else if (q.line_idx == fe_idx)
          begin
            d.fe = 1'b1;
            d.in_frame = 1'b0;
          end
          else
            d.blank = 1'b1;
          // Wrap once the programmed total has elapsed.
          if (next_idx >= tot_lines || next_idx == 16'h0000)
            d.line_idx = 16'h0000;
          else
            d.line_idx = next_idx;
        end
      end
      default:
      begin
        d.st = tpg_pkg::ST_OFF;
        d.line_idx = 16'h0000;
        d.in_frame = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      q <= '0;
      q.regs <= reg_defaults();
      q.st <= tpg_pkg::ST_OFF;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Line timer and byte emitter
  // ----------------------------------------------------------------
  tpg_tick u_tick (
    .core_clk     (core_clk),
    .srst         (srst),
    .run          (q.st == tpg_pkg::ST_RUN),
    .period_ticks (period),
    .line_tick    (line_tick)
  );

  tpg_line u_line (
    .core_clk   (core_clk),
    .srst       (srst),
    .cfg        (cfg.dst),
    .line_go    (q.go),
    .byte_valid (byte_valid),
    .bar_index  (bar_index),
    .line_first (line_first),
    .line_last  (line_last),
    .line_busy  (line_busy)
  );

  assign reg_rdata    = q.rdata;
  assign frame_start  = q.fs;
  assign frame_end    = q.fe;
  assign blank_line   = q.blank;
  assign frame_active = q.in_frame;

endmodule // tpg_top

// *** tb/tpg_top_chk.sv ***
// Concurrent checks on the ports of the frame timing core.
// Assumes it is bound to tpg_top and sees only that module's ports.
module tpg_top_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       frame_start,
  input wire logic       frame_end,
  input wire logic       frame_active,
  input wire logic       byte_valid,
  input wire logic [2:0] bar_index,
  input wire logic       line_first,
  input wire logic       line_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  first_byte_a: assert property (
    line_first |-> byte_valid && bar_index == 3'h0)
    else $error("First byte is not in bar zero.");
  line_open_a: assert property (
    $rose(byte_valid) |-> line_first)
    else $error("Line began without a first byte mark.");
  line_close_a: assert property (
    line_last |-> byte_valid ##1 !byte_valid)
    else $error("Bytes continued past the last byte.");
  bar_step_a: assert property (
    byte_valid && !line_last |=> byte_valid &&
      (bar_index == $past(bar_index) ||
       bar_index == $past(bar_index) + 3'h1))
    else $error("Line broke or bar index jumped.");
  frame_close_a: assert property (
    frame_end |-> !frame_active && $past(frame_active) ##1 !frame_active)
    else $error("Frame stayed active after frame end.");
  frame_open_a: assert property (
    $rose(frame_active) |-> frame_start || $past(frame_start))
    else $error("Frame became active without frame start.");
  bytes_framed_a: assert property (
    byte_valid |-> frame_active)
    else $error("Payload byte outside a frame.");
  unmapped_rd_a: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rdata == 8'h00)
    else $error("Unmapped offset read back nonzero.");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");
endmodule // tpg_top_chk

// *** tb/tpg_top_tb_top.sv ***
// Self-checking bench for the frame timing core.
// Assumes the checker and transmitter model are compiled before it.
module tpg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk;
  logic       srst;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       frame_start;
  logic       frame_end;
  logic       blank_line;
  logic       frame_active;
  logic       byte_valid;
  logic [2:0] bar_index;
  logic       line_first;
  logic       line_last;
  int         fails;
  int         total_checks;
  localparam logic [15:0] LEN = 16'h001E;
  localparam logic [15:0] BW  = 16'h0003;
  localparam logic [15:0] ACT = 16'h0003;
  localparam logic [15:0] TOT = 16'h000C;
  localparam logic [15:0] PRD = 16'h0028;
  localparam logic [15:0] VBP = 16'h0002;
  localparam logic [15:0] VFP = 16'h0002;

  tpg_top DUT (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_start(frame_start),
    .frame_end(frame_end), .blank_line(blank_line),
    .frame_active(frame_active), .byte_valid(byte_valid),
    .bar_index(bar_index), .line_first(line_first),
    .line_last(line_last));
  tpg_tx_model u_tx (.core_clk(core_clk), .srst(srst),
    .frame_start(frame_start), .frame_end(frame_end),
    .blank_line(blank_line), .byte_valid(byte_valid),
    .bar_index(bar_index), .line_first(line_first),
    .line_last(line_last));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask

  // Returns the negedges waited before frame_start, not the one after it; a limit that runs out ends the run.
  task automatic wait_fs(output int n);
    n = 0;
    while (frame_start !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 2000)
      begin
        fails++;
        $display("Error frame_start timeout");
        close_out();
      end
    end
    @(negedge core_clk);
  endtask

  task automatic t_reset_vals;
    logic [7:0] exp [12];
    logic [7:0] d;
    exp = '{tpg_pkg::RST_LINE_LEN_HI, tpg_pkg::RST_LINE_LEN_LO,
      tpg_pkg::RST_BAR_WID_HI, tpg_pkg::RST_BAR_WID_LO,
      tpg_pkg::RST_ACT_HI, tpg_pkg::RST_ACT_LO, tpg_pkg::RST_TOT_HI,
      tpg_pkg::RST_TOT_LO, tpg_pkg::RST_PERIOD_HI,
      tpg_pkg::RST_PERIOD_LO, tpg_pkg::RST_BACK_PORCH,
      tpg_pkg::RST_FRONT_PORCH};
    for (int i = 0; i < 12; i++)
    begin
      rd(8'h04 + 8'(i), d);
      check("reset value", d, exp[i]);
    end
    rd(tpg_pkg::OFS_CFG, d);
    check("bar count default", d[5:4], 2'h3);
    wr(8'h03, 8'hFF);
    rd(8'h03, d);
    check("unmapped read", d, 8'h00);
  endtask

  task automatic t_program;
    logic [7:0] h;
    logic [7:0] l;
    wr16(tpg_pkg::OFS_LINE_LEN_HI, LEN);
    wr16(tpg_pkg::OFS_BAR_WID_HI, BW);
    wr16(tpg_pkg::OFS_ACT_HI, ACT);
    wr16(tpg_pkg::OFS_TOT_HI, TOT);
    wr16(tpg_pkg::OFS_PERIOD_HI, PRD);
    wr(tpg_pkg::OFS_BACK_PORCH, VBP[7:0]);
    wr(tpg_pkg::OFS_FRONT_PORCH, VFP[7:0]);
    rd(tpg_pkg::OFS_PERIOD_HI, h);
    rd(tpg_pkg::OFS_PERIOD_LO, l);
    check("line period", {h, l}, PRD);
  endtask

  task automatic t_bars(input logic [1:0] code);
    int n;
    int w;
    logic [15:0] e;
    logic [7:0]  s;
    logic [7:0]  h;
    logic [7:0]  l;
    n = 1 << code;
    wr(tpg_pkg::OFS_CTRL, 8'h00);
    wr(tpg_pkg::OFS_CFG, {2'b00, code, 4'h3});
    wr(tpg_pkg::OFS_CTRL, 8'h01);
    wait_fs(w);
    check("start latency", 16'(w), 16'h0004);
    wait_fs(w);
    check("line bytes", u_tx.line_bytes, LEN);
    for (int b = 0; b < 8; b++)
    begin
      e = (b < n - 1) ? BW :
          (b == n - 1) ? 16'(LEN - BW * (n - 1)) : 16'h0000;
      check("bar bytes", u_tx.bar_done[b], e);
    end
    check("active lines", u_tx.done_lines, ACT);
    check("back porch", u_tx.done_pre, VBP);
    check("front porch", u_tx.done_post, VFP);
    e = 16'(TOT * PRD * tpg_pkg::CYC_PER_TICK);
    check("frame cycles", u_tx.done_cyc, e);
    // Just after frame start: running, in a frame, no line, index one.
    rd(tpg_pkg::OFS_STATUS, s);
    check("status running", s, 8'h03);
    rd(tpg_pkg::OFS_LINE_IDX_HI, h);
    rd(tpg_pkg::OFS_LINE_IDX_LO, l);
    check("line index", {h, l}, 16'h0001);
  endtask

  task automatic t_disable;
    int seen;
    logic [7:0] s;
    seen = 0;
    wr(tpg_pkg::OFS_CTRL, 8'h00);
    repeat (TOT * PRD + 100)
    begin
      @(negedge core_clk);
      if (frame_start !== 1'b0)
        seen++;
    end
    check("frames while off", 16'(seen), 16'h0000);
    rd(tpg_pkg::OFS_STATUS, s);
    check("status off", s, 8'h00);
  endtask

  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    t_reset_vals();
    t_program();
    for (int c = 0; c < 4; c++)
      t_bars(2'(c));
    t_disable();
    close_out();
  end
endmodule // tpg_top_tb_top

bind tpg_top tpg_top_chk u_chk (.core_clk(core_clk), .srst(srst),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .frame_start(frame_start), .frame_end(frame_end),
  .frame_active(frame_active), .byte_valid(byte_valid),
  .bar_index(bar_index), .line_first(line_first),
  .line_last(line_last));

// *** tb/tpg_tx_model.sv ***
// Behavioural model of the packet transmitter fed by the frame core.
// Assumes it only observes the stream outputs on core_clk.
module tpg_tx_model (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       frame_start,
  input wire logic       frame_end,
  input wire logic       blank_line,
  input wire logic       byte_valid,
  input wire logic [2:0] bar_index,
  input wire logic       line_first,
  input wire logic       line_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cyc;
  logic [15:0] lines;
  logic [15:0] pre;
  logic [15:0] post;
  logic [15:0] nb;
  logic [15:0] done_cyc;
  logic [15:0] done_lines;
  logic [15:0] done_pre;
  logic [15:0] done_post;
  logic [15:0] line_bytes;
  logic [15:0] bar_n [8];
  logic [15:0] bar_done [8];
  logic        in_frame;

  // Counts update in place so a whole line or frame is judged at once.
  always @(posedge core_clk)
  begin
    if (srst)
      in_frame = 1'b0;
    else
    begin
      if (frame_start)
      begin
        done_cyc = cyc;
        done_lines = lines;
        done_pre = pre;
        done_post = post;
        cyc = 16'h0000;
        lines = 16'h0000;
        pre = 16'h0000;
        post = 16'h0000;
        in_frame = 1'b1;
      end
      if (frame_end)
        in_frame = 1'b0;
      if (blank_line && in_frame)
      begin
        if (lines == 16'h0000)
          pre++;
        else
          post++;
      end
      if (byte_valid)
      begin
        if (line_first)
        begin
          nb = 16'h0000;
          foreach (bar_n[b]) bar_n[b] = 16'h0000;
        end
        nb++;
        bar_n[bar_index]++;
        if (line_last)
        begin
          line_bytes = nb;
          bar_done = bar_n;
          lines++;
          post = 16'h0000;
        end
      end
      cyc++;
    end
  end
endmodule // tpg_tx_model
